// file: core/bkpu_pkg.sv
/*
  Package for the breakpoint unit: register offsets, field positions,
  reset values and the encodings of the bus cycle attributes.
  Assumes a 32-bit APB slave with one register per aligned word.
*/
package bkpu_pkg;

  // --------------------------------------------------------------
  // Register indices as printed (word indices), byte addr = 4*idx
  // --------------------------------------------------------------
  localparam logic [27:0] BKPU_IDX_ADDR_HIGH = 28'h5ffff90;
  localparam logic [27:0] BKPU_IDX_ADDR_LOW = 28'h5ffff92;
  localparam logic [27:0] BKPU_IDX_MASK_HIGH = 28'h5ffff94;
  localparam logic [27:0] BKPU_IDX_MASK_LOW = 28'h5ffff96;
  localparam logic [27:0] BKPU_IDX_CYCLE_COND = 28'h5ffff98;
  localparam logic [27:0] BKPU_IDX_IRQ_STATUS = 28'h5ffff9a;
  localparam logic [27:0] BKPU_IDX_IRQ_MASK = 28'h5ffff9c;

  // --------------------------------------------------------------
  // Field positions of the cycle condition register
  // --------------------------------------------------------------
  localparam int BKPU_MASTER_SEL_LSB = 6;
  localparam int BKPU_ACCESS_TYPE_LSB = 4;
  localparam int BKPU_DIRECTION_LSB = 2;
  localparam int BKPU_SIZE_LSB = 0;
  localparam logic [15:0] BKPU_COND_WMASK = 16'h00ff;

  // --------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------
  localparam logic [15:0] BKPU_REG_RESET = 16'h0000;
  localparam logic [0:0] BKPU_IRQ_RESET = 1'h0;

  // --------------------------------------------------------------
  // Cycle attribute encodings
  // --------------------------------------------------------------
  localparam logic [1:0] BKPU_SIZE_ANY = 2'h0;
  localparam logic [1:0] BKPU_SIZE_BYTE = 2'h1;
  localparam logic [1:0] BKPU_SIZE_WORD = 2'h2;
  localparam logic [1:0] BKPU_SIZE_LONG = 2'h3;

endpackage

// file: core/bkpu_breakpoint_unit.sv
/*
  Breakpoint unit: compares each watched bus cycle with a programmed
  address under a mask and with master, type, direction and size
  conditions, and raises a sticky user break interrupt.
  Assumes monitored cycle attributes are synchronous to core_clk and
  held valid for the cycle in which cyc_valid is high.
*/
// Design decision made here: the APB register port.
// Behaviour
// - The high address register holds break address bits 31 to 16.
// - The low address register holds break address bits 15 to 0.
// - The high mask register masks address bits 31 to 16 out of the compare.
// - The low mask register masks address bits 15 to 0 out of the compare.
// - Master select 00 disables breaks, 01 processor, 10 DMA, 11 both.
// - Access type 00 disables breaks, 01 fetch, 10 data, 11 both.
// - Direction 00 disables breaks, 01 read, 10 write, 11 both.
// - Size 00 ignores size, 01 byte, 10 word, 11 longword.
`timescale 1ns/1ps
module bkpu_breakpoint_unit (
  input wire logic core_clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Monitored bus cycle
  input wire logic cyc_valid,
  input wire logic [31:0] cyc_addr,
  input wire logic cyc_is_dma,
  input wire logic cyc_is_data,
  input wire logic cyc_is_write,
  input wire logic [1:0] cyc_size,
  // Break outputs
  output logic break_hit,
  output logic break_irq
);
  import bkpu_pkg::*;

  // --------------------------------------------------------------
  // Reset synchroniser
  // --------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // --------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------
  logic [15:0] addr_high_reg;
  logic [15:0] addr_low_reg;
  logic [15:0] mask_high_reg;
  logic [15:0] mask_low_reg;
  logic [15:0] cond_reg;
  logic status_reg;
  logic irq_mask_reg;
  logic [31:0] prdata_reg;
  logic break_hit_reg;
  logic status_next;

  // --------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------
  function automatic logic sel_reg(input logic [31:0] a, input logic [27:0] idx);
    sel_reg = (a == {2'b00, idx, 2'b00}) ? 1'b1 : 1'b0;
  endfunction

  logic acc;
  logic wr_en;
  logic rd_en;
  logic hit_ah;
  logic hit_al;
  logic hit_mh;
  logic hit_ml;
  logic hit_cc;
  logic hit_st;
  logic hit_im;
  logic mapped;
  logic [15:0] wdata16;
  logic [15:0] lane_mask;
  logic [15:0] rd_mux;
  logic rd_setup;
  logic [31:0] prdata_next;

  // Access phase qualifies every write; read data is selected in the setup phase
  assign acc = psel & penable;
  assign wr_en = acc & pwrite;
  assign rd_en = acc & ~pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign hit_ah = sel_reg(paddr, BKPU_IDX_ADDR_HIGH);
  assign hit_al = sel_reg(paddr, BKPU_IDX_ADDR_LOW);
  assign hit_mh = sel_reg(paddr, BKPU_IDX_MASK_HIGH);
  assign hit_ml = sel_reg(paddr, BKPU_IDX_MASK_LOW);
  assign hit_cc = sel_reg(paddr, BKPU_IDX_CYCLE_COND);
  assign hit_st = sel_reg(paddr, BKPU_IDX_IRQ_STATUS);
  assign hit_im = sel_reg(paddr, BKPU_IDX_IRQ_MASK);
  assign mapped = hit_ah | hit_al | hit_mh | hit_ml | hit_cc | hit_st | hit_im;
  assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wdata16 = pwdata[15:0];

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // Read selection
  always_comb begin
    if (hit_ah) begin
      rd_mux = addr_high_reg;
    end else if (hit_al) begin
      rd_mux = addr_low_reg;
    end else if (hit_mh) begin
      rd_mux = mask_high_reg;
    end else if (hit_ml) begin
      rd_mux = mask_low_reg;
    end else if (hit_cc) begin
      rd_mux = cond_reg;
    end else if (hit_st) begin
      rd_mux = {15'h0, status_reg};
    end else if (hit_im) begin
      rd_mux = {15'h0, irq_mask_reg};
    end else begin
      rd_mux = 16'h0000;
    end
  end

  // --------------------------------------------------------------
  // Byte-lane merge for writes
  // --------------------------------------------------------------
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [15:0] lm);
    merge = (old & ~lm) | (nw & lm);
  endfunction

  // Break address registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_high_reg <= BKPU_REG_RESET;
      addr_low_reg <= BKPU_REG_RESET;
    end else begin
      if (wr_en && hit_ah) begin
        addr_high_reg <= merge(addr_high_reg, wdata16, lane_mask);
      end
      if (wr_en && hit_al) begin
        addr_low_reg <= merge(addr_low_reg, wdata16, lane_mask);
      end
    end
  end

  // Mask registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_high_reg <= BKPU_REG_RESET;
      mask_low_reg <= BKPU_REG_RESET;
    end else begin
      if (wr_en && hit_mh) begin
        mask_high_reg <= merge(mask_high_reg, wdata16, lane_mask);
      end
      if (wr_en && hit_ml) begin
        mask_low_reg <= merge(mask_low_reg, wdata16, lane_mask);
      end
    end
  end

  // Cycle condition and interrupt mask; upper condition bits read zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cond_reg <= BKPU_REG_RESET;
      irq_mask_reg <= BKPU_IRQ_RESET;
    end else begin
      if (wr_en && hit_cc) begin
        cond_reg <= merge(cond_reg, wdata16, lane_mask & BKPU_COND_WMASK);
      end
      if (wr_en && hit_im && pstrb[0]) begin
        irq_mask_reg <= pwdata[0];
      end
    end
  end

  // --------------------------------------------------------------
  // Cycle comparison
  // --------------------------------------------------------------
  logic [31:0] break_addr;
  logic [31:0] ignore_bits;
  logic addr_ok;
  logic master_ok;
  logic type_ok;
  logic dir_ok;
  logic size_ok;
  logic match;
  logic [1:0] master_sel;
  logic [1:0] type_sel;
  logic [1:0] dir_sel;
  logic [1:0] size_sel;

  // Field extraction
  assign break_addr = {addr_high_reg, addr_low_reg};
  assign ignore_bits = {mask_high_reg, mask_low_reg};
  assign master_sel = cond_reg[BKPU_MASTER_SEL_LSB +: 2];
  assign type_sel = cond_reg[BKPU_ACCESS_TYPE_LSB +: 2];
  assign dir_sel = cond_reg[BKPU_DIRECTION_LSB +: 2];
  assign size_sel = cond_reg[BKPU_SIZE_LSB +: 2];

  // Per-condition checks; a 00 master, type or direction selection never matches, size 00 matches any size
  assign addr_ok = (((cyc_addr ^ break_addr) & ~ignore_bits) == 32'h00000000);
  assign master_ok = cyc_is_dma ? master_sel[1] : master_sel[0];
  assign type_ok = cyc_is_data ? type_sel[1] : type_sel[0];
  assign dir_ok = cyc_is_write ? dir_sel[1] : dir_sel[0];
  assign size_ok = (size_sel == BKPU_SIZE_ANY) || (size_sel == cyc_size);
  assign match = cyc_valid & addr_ok & master_ok & type_ok & dir_ok & size_ok;

  // Sticky status: a new hit wins over a write-one clear
  assign status_next = match | (status_reg & ~(wr_en & hit_st & pstrb[0] & pwdata[0]));

  // Read data captured in the setup cycle, zero in every other cycle
  assign prdata_next = rd_setup ? {16'h0000, rd_mux} : 32'h00000000;

  // Status, hit pulse and read data flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= BKPU_IRQ_RESET;
      break_hit_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      status_reg <= status_next;
      break_hit_reg <= match;
      prdata_reg <= prdata_next;
    end
  end

  // Read data stands from a flop for the access phase only
  assign prdata = prdata_reg;
  assign break_hit = break_hit_reg;
  assign break_irq = status_reg & irq_mask_reg;

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  sequence s_hit_cycle;
    cyc_valid && addr_ok && master_ok && type_ok && dir_ok && size_ok;
  endsequence

  a_hit_sets_status: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_hit_cycle |=> status_reg && break_hit)
    else $error("matching cycle did not set break status");

  a_master_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    (master_sel == 2'h0) |-> !match)
    else $error("break with master select disabled");

  a_type_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    (type_sel == 2'h0) |-> !match)
    else $error("break with access type disabled");

  a_dir_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    (dir_sel == 2'h0) |-> !match)
    else $error("break with direction disabled");

  a_size_wrong: assert property (@(posedge core_clk) disable iff (!rst_n)
    (size_sel != BKPU_SIZE_ANY && size_sel != cyc_size) |-> !match)
    else $error("break on wrong operand size");

  a_mask_exact: assert property (@(posedge core_clk) disable iff (!rst_n)
    match |-> ((cyc_addr & ~ignore_bits) == (break_addr & ~ignore_bits)))
    else $error("break on unmasked address mismatch");

  a_high_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_en && hit_ah && pstrb[1:0] == 2'h3) |=> addr_high_reg == $past(pwdata[15:0]))
    else $error("high address write lost");

  a_low_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_en && hit_al && pstrb[1:0] == 2'h3) |=> addr_low_reg == $past(pwdata[15:0]))
    else $error("low address write lost");

  a_mask_high_wr: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_en && hit_mh && pstrb[1:0] == 2'h3) |=> mask_high_reg == $past(pwdata[15:0]))
    else $error("high mask write lost");

  a_mask_low_wr: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_en && hit_ml && pstrb[1:0] == 2'h3) |=> mask_low_reg == $past(pwdata[15:0]))
    else $error("low mask write lost");

  // Read transfer: setup cycle, then access phase of the same request
  sequence s_read_setup;
    psel && !penable && !pwrite;
  endsequence

  sequence s_read_access;
    psel && penable && !pwrite;
  endsequence

  // Write-one clear of the sticky status bit
  sequence s_status_clear;
    wr_en && hit_st && pstrb[0] && pwdata[0];
  endsequence

  a_read_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_read_setup ##1 s_read_access |-> prdata[31:16] == 16'h0000)
    else $error("register read drives upper half");

  a_read_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    (psel && !penable && !pwrite && hit_ah) ##1 s_read_access |-> prdata[15:0] == addr_high_reg)
    else $error("high address read data wrong");

  a_read_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    (psel && !penable && !pwrite && hit_al) ##1 s_read_access |-> prdata[15:0] == addr_low_reg)
    else $error("low address read data wrong");

  a_clear_status: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_status_clear ##0 !match |=> !status_reg)
    else $error("status bit not cleared by write of one");

  a_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_status_clear ##0 match |=> status_reg)
    else $error("clear won over a new hit");

  a_no_false_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!match && !status_reg) |=> !status_reg)
    else $error("status set without a matching cycle");

  a_hit_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    !match |=> !break_hit)
    else $error("hit pulse without a matching cycle");

  a_cond_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
    cond_reg[15:8] == 8'h00)
    else $error("condition upper bits not zero");

  a_size_any: assert property (@(posedge core_clk) disable iff (!rst_n)
    (size_sel == BKPU_SIZE_ANY && cyc_valid && addr_ok && master_ok && type_ok && dir_ok) |-> match)
    else $error("size ignored setting blocked a break");

endmodule

// file: dv/bkpu_cycle_src.sv
/*
  Bus cycle source standing in for the processor core and DMA controller.
  Assumes the unit under test samples cyc_valid on rising core_clk edges.
*/
`timescale 1ns/1ps
module bkpu_cycle_src (
  input wire logic core_clk,
  output logic cyc_valid,
  output logic [31:0] cyc_addr,
  output logic cyc_is_dma,
  output logic cyc_is_data,
  output logic cyc_is_write,
  output logic [1:0] cyc_size
);
  // Idle bus at time zero
  initial begin
    cyc_valid = 1'b0;
    cyc_addr = 32'h0;
    {cyc_is_dma, cyc_is_data, cyc_is_write, cyc_size} = 5'h0;
  end

  // One-clock cycle; afterwards the lines show inverted stale values
  task automatic go(input logic [31:0] a, input logic [4:0] at);
    @(posedge core_clk);
    cyc_valid <= 1'b1;
    cyc_addr <= a;
    {cyc_is_dma, cyc_is_data, cyc_is_write, cyc_size} <= at;
    @(posedge core_clk);
    cyc_valid <= 1'b0;
    cyc_addr <= ~a;
    {cyc_is_dma, cyc_is_data, cyc_is_write, cyc_size} <= ~at;
  endtask
endmodule

// file: dv/test_user_break_comparator.sv
/*
  Self-checking bench for the breakpoint unit: APB master, cycle table.
  Assumes a zero-or-more wait APB slave and the bkpu_cycle_src model.
*/
`timescale 1ns/1ps
module test_user_break_comparator;
  import bkpu_pkg::*;
  typedef struct packed {
    logic [7:0] cond;
    logic [31:0] xr;
    logic [31:0] mk;
    logic [4:0] at;
    logic hit;
  } bkpu_row_t;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h3;
  logic [31:0] prdata, rdat, cyc_addr;
  logic pready, pslverr, rerr, break_hit, break_irq;
  logic cyc_valid, cyc_is_dma, cyc_is_data, cyc_is_write;
  logic [1:0] cyc_size;
  int n_errors = 0;
  int n_compared = 0;
  logic [27:0] regs [7] = '{BKPU_IDX_ADDR_HIGH, BKPU_IDX_ADDR_LOW, BKPU_IDX_MASK_HIGH,
    BKPU_IDX_MASK_LOW, BKPU_IDX_CYCLE_COND, BKPU_IDX_IRQ_STATUS, BKPU_IDX_IRQ_MASK};
  // Attributes: dma, data, write, size; break address 0x12345678
  bkpu_row_t rows [20] = '{
    '{8'hfc, 32'h0, 32'h0, 5'h01, 1'b1}, '{8'h3c, 32'h0, 32'h0, 5'h01, 1'b0},
    '{8'h7c, 32'h0, 32'h0, 5'h11, 1'b0}, '{8'h7c, 32'h0, 32'h0, 5'h01, 1'b1},
    '{8'hbc, 32'h0, 32'h0, 5'h11, 1'b1}, '{8'hcc, 32'h0, 32'h0, 5'h01, 1'b0},
    '{8'hdc, 32'h0, 32'h0, 5'h09, 1'b0}, '{8'hdc, 32'h0, 32'h0, 5'h01, 1'b1},
    '{8'hec, 32'h0, 32'h0, 5'h09, 1'b1}, '{8'hf0, 32'h0, 32'h0, 5'h01, 1'b0},
    '{8'hf4, 32'h0, 32'h0, 5'h05, 1'b0}, '{8'hf4, 32'h0, 32'h0, 5'h01, 1'b1},
    '{8'hf8, 32'h0, 32'h0, 5'h05, 1'b1}, '{8'hfd, 32'h0, 32'h0, 5'h02, 1'b0},
    '{8'hfe, 32'h0, 32'h0, 5'h02, 1'b1}, '{8'hff, 32'h0, 32'h0, 5'h03, 1'b1},
    '{8'hfc, 32'h80000000, 32'h0, 5'h01, 1'b0}, '{8'hfc, 32'h80000000, 32'h80000000, 5'h01, 1'b1},
    '{8'hfc, 32'h1, 32'h0, 5'h01, 1'b0}, '{8'hfc, 32'h1, 32'h1, 5'h01, 1'b1}};

  // --------------------------------------------------------------
  // Clock, design and cycle source
  // --------------------------------------------------------------
  always #2.5 core_clk = ~core_clk;
  bkpu_breakpoint_unit DUT (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr),
    .cyc_is_dma(cyc_is_dma), .cyc_is_data(cyc_is_data), .cyc_is_write(cyc_is_write),
    .cyc_size(cyc_size), .break_hit(break_hit), .break_irq(break_irq));
  bkpu_cycle_src src (.core_clk(core_clk), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr),
    .cyc_is_dma(cyc_is_dma), .cyc_is_data(cyc_is_data), .cyc_is_write(cyc_is_write),
    .cyc_size(cyc_size));

  // --------------------------------------------------------------
  // Bus and check tasks
  // --------------------------------------------------------------
  function automatic logic [31:0] ba(input logic [27:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction
  // Setup, access until pready, take data at that edge, release
  task automatic apb(input logic w, input logic [31:0] a, input logic [15:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [27:0] x, input logic [15:0] d);
    apb(1'b1, ba(x), d);
  endtask
  task automatic rdc(input logic [27:0] x, input logic [31:0] e, input string nm);
    apb(1'b0, ba(x), 16'h0);
    chk(nm, e, rdat);
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int k = 0; k < 7; k++) begin
      rdc(regs[k], 32'h0, "reset value");
    end
    $display("test reset values done");
    wr(BKPU_IDX_ADDR_HIGH, 16'h1234);
    wr(BKPU_IDX_ADDR_LOW, 16'h5678);
    wr(BKPU_IDX_MASK_HIGH, 16'ha5a5);
    wr(BKPU_IDX_MASK_LOW, 16'h5a5a);
    wr(BKPU_IDX_CYCLE_COND, 16'hffff);
    rdc(BKPU_IDX_ADDR_HIGH, 32'h1234, "addr high");
    chk("mapped error", 32'h0, {31'h0, rerr});
    rdc(BKPU_IDX_ADDR_LOW, 32'h5678, "addr low");
    rdc(BKPU_IDX_MASK_HIGH, 32'ha5a5, "mask high");
    rdc(BKPU_IDX_MASK_LOW, 32'h5a5a, "mask low");
    rdc(BKPU_IDX_CYCLE_COND, 32'h00ff, "cond");
    apb(1'b0, ba(28'h5ffff91), 16'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rdat);
    $display("test registers done");
    // One watched cycle per row, hit seen the cycle after
    foreach (rows[k]) begin
      wr(BKPU_IDX_CYCLE_COND, {8'h0, rows[k].cond});
      wr(BKPU_IDX_MASK_HIGH, rows[k].mk[31:16]);
      wr(BKPU_IDX_MASK_LOW, rows[k].mk[15:0]);
      src.go(32'h12345678 ^ rows[k].xr, rows[k].at);
      #1;
      chk("break_hit", {31'h0, rows[k].hit}, {31'h0, break_hit});
    end
    $display("test cycle table done");
    chk("irq masked", 32'h0, {31'h0, break_irq});
    rdc(BKPU_IDX_IRQ_STATUS, 32'h1, "irq status");
    wr(BKPU_IDX_IRQ_MASK, 16'h1);
    #1;
    chk("irq unmasked", 32'h1, {31'h0, break_irq});
    wr(BKPU_IDX_IRQ_STATUS, 16'h1);
    #1;
    chk("irq cleared", 32'h0, {31'h0, break_irq});
    src.go(32'h12345679, 5'h01);
    #1;
    chk("irq raised", 32'h1, {31'h0, break_irq});
    @(posedge core_clk);
    #1;
    chk("hit pulse end", 32'h0, {31'h0, break_hit});
    // Clear and new hit in one cycle: the hit must win
    fork
      wr(BKPU_IDX_IRQ_STATUS, 16'h1);
      begin
        @(posedge core_clk);
        src.go(32'h12345678, 5'h01);
      end
    join
    #1;
    chk("set wins", 32'h1, {31'h0, break_irq});
    $display("test interrupt done");
    // Low byte lane only
    pstrb <= 4'h1;
    wr(BKPU_IDX_ADDR_LOW, 16'habcd);
    pstrb <= 4'h3;
    rdc(BKPU_IDX_ADDR_LOW, 32'h56cd, "low lane write");
    $display("test byte lanes done");
    // Reset in mid-run clears interrupt and every register
    rstn <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("irq in reset", 32'h0, {31'h0, break_irq});
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    foreach (regs[k]) begin
      rdc(regs[k], 32'h0, "reset again");
    end
    $display("test mid-run reset done");
    finish_test();
  end

  // Watchdog far beyond the expected run
  initial begin
    #20000;
    n_errors++;
    finish_test();
  end
endmodule
